// File: oled_delay_timer.sv
// loadable down counter giving a done pulse
`timescale 1ns/10ps
module oled_delay_timer #(
    parameter int W = 24
) (
    input  wire logic         clk_sys, // system clock
    input  wire logic         reset_n, // async reset, active low
    input  wire logic         load,    // load a new count
    input  wire logic [W-1:0] count,   // cycles to wait
    output logic              busy,    // counting
    output logic              done     // one-cycle pulse at end
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic         busy;
        logic         done;
    } tmr_t;
    tmr_t s_q, s_d;

    // count down then pulse done once
    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        if (load) begin
            s_d.cnt  = count;
            s_d.busy = 1'b1;
        end else if (s_q.busy) begin
            if (s_q.cnt <= W'(1)) begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt - W'(1);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign busy = s_q.busy;
    assign done = s_q.done;
endmodule

// File: oled_dev_end.sv
// display controller end: reset state, transfer capture, driver enables
`include "oled_seq_regs.svh"
`timescale 1ns/10ps
module oled_dev_end
    import oled_seq_pkg::*;
(
    input  wire logic   clk_sys,        // system clock
    input  wire logic   reset_n,        // async reset, active low
    oled_link_if.dev    link,           // host side link
    input  wire logic   serial_bit,     // serial data input bit
    input  wire logic   serial_strobe,  // serial bit valid
    output logic        display_on,     // display enabled
    output logic        drivers_oe,     // segment and common drivers enabled
    output logic        seg_remap,      // segment remap selected
    output logic        com_reverse,    // common scan reversed
    output logic        ext_dcdc,       // external supply selected
    output logic [7:0]  contrast,       // contrast setting
    output logic [5:0]  start_line,     // display start line
    output logic [7:0]  column,         // column address counter
    output logic [7:0]  shift_reg,      // serial input shift register
    output logic        cmd_seen,       // pulse per accepted command
    output logic        data_seen       // pulse per accepted data byte
);
    typedef struct packed {
        logic [1:0] rst_sync;
        dev_cfg_t   cfg;
        logic [7:0] shift;
        logic       cmd_p;
        logic       data_p;
        logic       drv_oe;
    } dev_t;
    dev_t s_q, s_d;
    logic in_reset;

    assign in_reset = !s_q.rst_sync[1];

    // sync the reset pin, force reset state while low, accept transfers after
    always_comb begin
        s_d          = s_q;
        s_d.rst_sync = {s_q.rst_sync[0], link.hw_reset_n};
        s_d.cmd_p    = 1'b0;
        s_d.data_p   = 1'b0;
        if (in_reset) begin
            s_d.cfg.display_on  = 1'b0;
            s_d.drv_oe          = 1'b0;
            s_d.cfg.remap       = 1'b0;
            s_d.shift           = 8'h00;
            s_d.cfg.start_line  = `START_LINE_RST;
            s_d.cfg.column      = `COLUMN_RST;
            s_d.cfg.com_reverse = 1'b0;
            s_d.cfg.contrast    = `CONTRAST_RST;
            s_d.cfg.ext_dcdc    = 1'b0;
        end else begin
            if (serial_strobe) begin
                s_d.shift = {s_q.shift[6:0], serial_bit};
            end
            if (link.xfer_valid) begin
                if (link.xfer_is_data) begin
                    s_d.data_p     = 1'b1;
                    s_d.cfg.column = s_q.cfg.column + 8'h01;
                end else begin
                    s_d.cmd_p = 1'b1;
                    case (link.xfer_byte)
                        `CMD_DISPLAY_ON: begin
                            s_d.cfg.display_on = 1'b1;
                            s_d.drv_oe         = 1'b1;
                        end
                        `CMD_DISPLAY_OFF: begin
                            s_d.cfg.display_on = 1'b0;
                            s_d.drv_oe         = 1'b0;
                        end
                        `CMD_CLEAR: s_d.cfg.column = `COLUMN_RST;
                        default: ;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            // reset value as one constant: all zero but the contrast setting
            s_q <= {2'b00, 4'h0, `CONTRAST_RST, `START_LINE_RST, `COLUMN_RST, 8'h00, 3'h0};
        end else begin
            s_q <= s_d;
        end
    end

    assign display_on  = s_q.cfg.display_on;
    assign drivers_oe  = s_q.drv_oe;
    assign seg_remap   = s_q.cfg.remap;
    assign com_reverse = s_q.cfg.com_reverse;
    assign ext_dcdc    = s_q.cfg.ext_dcdc;
    assign contrast    = s_q.cfg.contrast;
    assign start_line  = s_q.cfg.start_line;
    assign column      = s_q.cfg.column;
    assign shift_reg   = s_q.shift;
    assign cmd_seen    = s_q.cmd_p;
    assign data_seen   = s_q.data_p;
endmodule

// File: oled_host_end.sv
// host end: drives reset pulse, power-up and power-down sequences
`include "oled_seq_regs.svh"
`timescale 1ns/10ps
// How it works
// - reset held low initialises device; high otherwise
// - reset low at least 10us or 5us
// - reset turns display off, drivers high-impedance
// - reset selects normal segment and row mapping
// - reset clears serial input shift register
// - reset sets start line to zero
// - reset sets column counter to zero
// - reset selects normal common scan direction
// - reset loads contrast with 80 hex
// - reset selects internal dc-dc converter
// - display off, init, clear before panel supply
// - wait 200ms after supply, then display on
// - off, drop supply, wait 100ms, drop logic
// - reset and reinit after noise corruption
module oled_host_end
    import oled_seq_pkg::*;
#(
    parameter int SETTLE_CYC    = `VPP_SETTLE_CYC,
    parameter int DISCHARGE_CYC = `VPP_DISCHARGE_CYC,
    parameter int TW            = 24
)
(
    input  wire logic   clk_sys,    // system clock
    input  wire logic   reset_n,    // async reset, active low
    oled_link_if.host   link,       // device side link
    input  wire logic   wr_addr,    // register address, 0 control 1 status
    input  wire logic [7:0] wr_data, // write data
    input  wire logic   wr_stb,     // write strobe
    input  wire logic   rd_stb,     // read strobe
    input  wire logic   high_vdd,   // logic supply at or above 2.4 V
    output logic [7:0]  rd_data     // read data, cycle after rd_stb
);
    typedef struct packed {
        host_state_t state;
        logic [2:0]  step;
        logic        rst_n;
        logic        vpp;
        logic        vdd;
        logic        valid;
        logic        is_data;
        logic [7:0]  byte_o;
        logic [7:0]  rdat;
        logic        up_req;
        logic        down_req;
    } host_t;
    host_t s_q, s_d;
    logic          t_load;
    logic [TW-1:0] t_count;
    logic          t_busy;
    logic          t_done;

    oled_delay_timer #(.W(TW)) u_timer (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .load    (t_load),
        .count   (t_count),
        .busy    (t_busy),
        .done    (t_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // sequencer: control bit0 starts power up, bit1 power down, bit2 reset
    always_comb begin
        s_d         = s_q;
        s_d.valid   = 1'b0;
        s_d.is_data = 1'b0;
        t_load      = 1'b0;
        t_count     = '0;
        s_d.rdat    = {s_q.state};
        if (rd_stb && wr_addr) begin
            s_d.rdat = {t_busy, s_q.vdd, s_q.vpp, s_q.rst_n, 1'b0, s_q.step};
        end
        if (wr_stb && !wr_addr) begin
            s_d.up_req   = s_q.up_req | wr_data[0];
            s_d.down_req = s_q.down_req | wr_data[1];
            if (wr_data[2]) begin
                // blank the panel in the same cycle the panel supply drops
                s_d.up_req = 1'b1;
                s_d.valid  = 1'b1;
                s_d.byte_o = `CMD_DISPLAY_OFF;
                s_d.vpp    = 1'b0;
                s_d.state  = H_IDLE;
            end
        end
        case (s_q.state)
            H_IDLE: begin
                if (s_d.up_req) begin
                    s_d.up_req = 1'b0;
                    s_d.vdd    = 1'b1;
                    s_d.rst_n  = 1'b0;
                    s_d.state  = H_RST_LOW;
                    t_load     = 1'b1;
                    t_count    = high_vdd ? TW'(`RESET_LOW_CYC_HIGHV)
                                          : TW'(`RESET_LOW_CYC_LOWV);
                end
            end
            H_RST_LOW: if (t_done) begin
                s_d.rst_n = 1'b1;
                s_d.state = H_RST_WAIT;
                t_load    = 1'b1;
                t_count   = TW'(`RESET_DONE_CYC);
            end
            H_RST_WAIT: if (t_done) begin
                s_d.state = H_INIT;
                s_d.step  = 3'h0;
            end
            H_INIT: begin
                s_d.valid = 1'b1;
                s_d.step  = s_q.step + 3'h1;
                case (s_q.step)
                    3'h0:    s_d.byte_o = `CMD_DISPLAY_OFF;
                    3'h1:    s_d.byte_o = `CMD_INIT;
                    default: s_d.byte_o = `CMD_CLEAR;
                endcase
                if (s_q.step == 3'h2) begin
                    s_d.vpp   = 1'b1;
                    s_d.state = H_SETTLE;
                    t_load    = 1'b1;
                    t_count   = TW'(SETTLE_CYC);
                end
            end
            H_SETTLE: if (t_done) begin
                s_d.valid  = 1'b1;
                s_d.byte_o = `CMD_DISPLAY_ON;
                s_d.state  = H_ON;
            end
            H_ON: if (s_d.down_req) begin
                s_d.down_req = 1'b0;
                s_d.valid    = 1'b1;
                s_d.byte_o   = `CMD_DISPLAY_OFF;
                s_d.vpp      = 1'b0;
                s_d.state    = H_DISCH;
                t_load       = 1'b1;
                t_count      = TW'(DISCHARGE_CYC);
            end
            H_DISCH: if (t_done) begin
                s_d.vdd   = 1'b0;
                s_d.rst_n = 1'b0;
                s_d.state = H_OFF;
            end
            H_OFF: s_d.state = H_IDLE;
            default: s_d.state = H_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s_q       <= '0;
            s_q.state <= H_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign link.hw_reset_n   = s_q.rst_n;
    assign link.xfer_valid   = s_q.valid;
    assign link.xfer_is_data = s_q.is_data;
    assign link.xfer_byte    = s_q.byte_o;
    assign link.vpp_en       = s_q.vpp;
    assign link.vdd_en       = s_q.vdd;
    assign rd_data           = s_q.rdat;
endmodule

// File: oled_link_if.sv
// link between host sequencer and display controller
`timescale 1ns/10ps
interface oled_link_if;
    logic       hw_reset_n;   // active-low hardware reset
    logic       xfer_valid;   // one-cycle transfer strobe
    logic       xfer_is_data; // high data, low command
    logic [7:0] xfer_byte;    // transfer payload
    logic       vpp_en;       // panel high-voltage supply enable
    logic       vdd_en;       // logic supply enable

    modport host (output hw_reset_n, xfer_valid, xfer_is_data, xfer_byte, vpp_en, vdd_en);
    modport dev  (input hw_reset_n, xfer_valid, xfer_is_data, xfer_byte, vpp_en, vdd_en);
endinterface

// File: oled_link_properties.sv
// concurrent checks on the link between the host and controller ends
`include "oled_seq_regs.svh"
`timescale 1ns/10ps
module oled_link_properties #(
    parameter int SETTLE_CYC    = 50,
    parameter int DISCHARGE_CYC = 50
) (
    input wire logic       clk_sys,      // system clock
    input wire logic       reset_n,      // async reset, active low
    input wire logic       hw_reset_n,   // controller reset
    input wire logic       xfer_valid,   // transfer strobe
    input wire logic       xfer_is_data, // data or command
    input wire logic [7:0] xfer_byte,    // payload
    input wire logic       vpp_en,       // panel supply
    input wire logic       vdd_en        // logic supply
);
    logic [31:0] lo_q, hi_q, vpp_q, off_q; // cycles spent in the present level; lo_q counts reset low only while vdd_en is high

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    ////////////////////////////////////////////////////////////////////////////////
    // level duration counters
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            lo_q  <= '0;
            hi_q  <= '0;
            vpp_q <= '0;
            off_q <= '0;
        end else begin
            lo_q  <= (hw_reset_n || !vdd_en) ? '0 : lo_q + 32'h1;
            hi_q  <= hw_reset_n ? hi_q + 32'h1 : '0;
            vpp_q <= vpp_en ? vpp_q + 32'h1 : '0;
            off_q <= vpp_en ? '0 : off_q + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // link sequencing checks
    a_pulse_width: assert property ($rose(hw_reset_n) |-> lo_q >= 32'hFA)
        else $error("controller reset pulse too short");
    a_reset_on_up: assert property ($rose(vdd_en) |-> !hw_reset_n [*8])
        else $error("reset not held low at logic power-up");
    a_quiet_reset: assert property (xfer_valid |-> hw_reset_n && hi_q >= 32'h64)
        else $error("transfer during or too soon after reset");
    a_prep_vpp: assert property ($rose(vpp_en) |-> xfer_valid && xfer_byte == `CMD_CLEAR
        && $past(xfer_byte, 1) == `CMD_INIT && $past(xfer_byte, 2) == `CMD_DISPLAY_OFF)
        else $error("panel supply raised before off, init and clear");
    a_settle_on: assert property (xfer_valid && xfer_byte == `CMD_DISPLAY_ON
        |-> vpp_en && vpp_q >= SETTLE_CYC)
        else $error("display on sent before panel supply settled");
    a_off_first: assert property ($fell(vpp_en) |-> xfer_valid
        && xfer_byte == `CMD_DISPLAY_OFF)
        else $error("panel supply dropped without display off");
    a_discharge_wait: assert property ($fell(vdd_en) |-> off_q >= DISCHARGE_CYC)
        else $error("logic supply dropped before discharge");
    a_vpp_in_vdd: assert property (vpp_en |-> vdd_en)
        else $error("panel supply on without logic supply");
    a_cmd_only: assert property (xfer_valid |-> !xfer_is_data)
        else $error("host sent a data byte");
endmodule

// File: oled_seq_pkg.sv
// types shared by both ends of the oled sequencer link
package oled_seq_pkg;
    typedef enum logic [7:0] {
        H_IDLE     = 8'h01,
        H_RST_LOW  = 8'h02,
        H_RST_WAIT = 8'h04,
        H_INIT     = 8'h08,
        H_SETTLE   = 8'h10,
        H_ON       = 8'h20,
        H_DISCH    = 8'h40,
        H_OFF      = 8'h80
    } host_state_t;

    typedef struct packed {
        logic       display_on;
        logic       remap;
        logic       com_reverse;
        logic       ext_dcdc;
        logic [7:0] contrast;
        logic [5:0] start_line;
        logic [7:0] column;
    } dev_cfg_t;
endpackage

// File: oled_seq_regs.svh
// timing constants and reset values for the oled reset and power sequencer
`ifndef OLED_SEQ_REGS_SVH
`define OLED_SEQ_REGS_SVH

`define CLK_FREQ_MHZ        50
`define RESET_LOW_US_LOWV   10
`define RESET_LOW_US_HIGHV  5
`define RESET_DONE_US       2
`define VPP_SETTLE_MS       200
`define VPP_DISCHARGE_MS    100
`define RESET_LOW_CYC_LOWV  (`RESET_LOW_US_LOWV * `CLK_FREQ_MHZ)
`define RESET_LOW_CYC_HIGHV (`RESET_LOW_US_HIGHV * `CLK_FREQ_MHZ)
`define RESET_DONE_CYC      (`RESET_DONE_US * `CLK_FREQ_MHZ)
`define VPP_SETTLE_CYC      (`VPP_SETTLE_MS * 1000 * `CLK_FREQ_MHZ)
`define VPP_DISCHARGE_CYC   (`VPP_DISCHARGE_MS * 1000 * `CLK_FREQ_MHZ)
`define CONTRAST_RST        8'h80
`define START_LINE_RST      6'h00
`define COLUMN_RST          8'h00
`define CMD_DISPLAY_OFF     8'hAE
`define CMD_DISPLAY_ON      8'hAF
`define CMD_CLEAR           8'h01
`define CMD_INIT            8'h02

`endif

// File: tb_oled_reset_power_sequencer.sv
// self-checking bench for the host and controller ends
`include "oled_seq_regs.svh"
`timescale 1ns/10ps
module tb_oled_reset_power_sequencer import oled_seq_pkg::*;;
    typedef struct packed {logic [34:0] m; logic [34:0] e;} note_t;
    localparam int          SETTLE    = 50; // shortened settle count
    localparam int          DISCHARGE = 50; // shortened discharge count
    localparam logic [34:0] DEV_RST   = {5'h00, 8'h80, 6'h00, 8'h00, 8'h00};
    logic        clk_sys = 1'b0, reset_n = 1'b0, wr_addr = 1'b0, wr_stb = 1'b0;
    logic        rd_stb = 1'b0, high_vdd = 1'b0, serial_bit = 1'b0, serial_strobe = 1'b0;
    logic        rd_pend = 1'b0;
    logic [7:0]  wr_data = 8'h00, rd_data, contrast, column, shift_reg;
    logic [5:0]  start_line;
    logic        display_on, drivers_oe, seg_remap, com_reverse, ext_dcdc;
    logic [34:0] dev_st;
    note_t       notes[$];
    note_t       nt;
    int          n_mismatch = 0, compares = 0, n;

    always #10 clk_sys = ~clk_sys;
    assign dev_st = {display_on, drivers_oe, seg_remap, com_reverse, ext_dcdc,
                     contrast, start_line, column, shift_reg};

    ////////////////////////////////////////////////////////////////////////////////
    // both ends joined by the link, checker beside it
    oled_link_if link ();
    oled_host_end #(.SETTLE_CYC(SETTLE), .DISCHARGE_CYC(DISCHARGE), .TW(24)) u_oled_host_end (
        .clk_sys(clk_sys), .reset_n(reset_n), .link(link), .wr_addr(wr_addr),
        .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .high_vdd(high_vdd),
        .rd_data(rd_data));
    oled_dev_end u_oled_dev_end (
        .clk_sys(clk_sys), .reset_n(reset_n), .link(link), .serial_bit(serial_bit),
        .serial_strobe(serial_strobe), .display_on(display_on), .drivers_oe(drivers_oe),
        .seg_remap(seg_remap), .com_reverse(com_reverse), .ext_dcdc(ext_dcdc),
        .contrast(contrast), .start_line(start_line), .column(column),
        .shift_reg(shift_reg), .cmd_seen(), .data_seen());
    oled_link_properties #(.SETTLE_CYC(SETTLE), .DISCHARGE_CYC(DISCHARGE)) u_oled_link_properties (
        .clk_sys(clk_sys), .reset_n(reset_n), .hw_reset_n(link.hw_reset_n),
        .xfer_valid(link.xfer_valid), .xfer_is_data(link.xfer_is_data),
        .xfer_byte(link.xfer_byte), .vpp_en(link.vpp_en), .vdd_en(link.vdd_en));

    ////////////////////////////////////////////////////////////////////////////////
    // verdict, comparison and bus tasks
    task automatic close_out();
        if (n_mismatch == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [34:0] got, input logic [34:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] d);
        @(posedge clk_sys);
        wr_addr <= 1'b0;
        wr_data <= d;
        wr_stb  <= 1'b1;
        @(posedge clk_sys);
        wr_stb  <= 1'b0;
    endtask

    task automatic rd(input logic a, input logic [7:0] m, input logic [7:0] e);
        notes.push_back(note_t'{35'(m), 35'(e)});
        @(posedge clk_sys);
        wr_addr <= a;
        rd_stb  <= 1'b1;
        @(posedge clk_sys);
        rd_stb  <= 1'b0;
    endtask

    // bounded wait for a line to take a level, n gives the cycles waited
    task automatic await(input int sel, input logic v, output int n);
        logic s;
        for (n = 0; n < 3000; n++) begin
            s = sel == 0 ? link.vdd_en : sel == 1 ? link.hw_reset_n : display_on;
            if (s === v) return;
            @(posedge clk_sys);
        end
        chk(35'h0, 35'h1); // waited too long
    endtask

    // random serial bits into the controller
    task automatic noise();
        repeat (30) begin
            @(posedge clk_sys);
            serial_bit    <= 1'($urandom);
            serial_strobe <= 1'($urandom);
        end
        @(posedge clk_sys);
        serial_strobe <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // compare each read answer with the oldest note
    always @(posedge clk_sys) begin
        if (rd_pend && notes.size() > 0) begin
            nt = notes.pop_front();
            chk({27'h0, rd_data} & nt.m, nt.e);
        end
        rd_pend <= rd_stb;
    end

    // cut a hang short
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        close_out();
    end

    // main sequence: two power cycles, low then high logic supply
    initial begin
        void'($urandom(32'hAD8D1268));
        for (int k = 0; k < 2; k++) begin
            repeat (10) @(posedge clk_sys);
            reset_n  <= 1'b1;
            high_vdd <= k[0];
            noise();
            chk(dev_st, DEV_RST);
            rd(1'b0, 8'hFF, H_IDLE);
            wr(8'h01);
            await(0, 1'b1, n);
            await(1, 1'b1, n);
            chk(35'(n >= (k ? 250 : 500)), 35'h1);
            await(2, 1'b1, n);
            chk(35'(n >= SETTLE), 35'h1);
            rd(1'b1, 8'h70, 8'h70);
            rd(1'b0, 8'hFF, H_ON);
            noise();
            wr(8'h04);
            await(1, 1'b0, n);
            repeat (5) @(posedge clk_sys);
            chk(dev_st, DEV_RST);
            await(1, 1'b1, n);
            chk(35'(n >= 240), 35'h1);
            await(2, 1'b1, n);
            chk(35'(display_on), 35'h1);
            wr(8'h02);
            await(0, 1'b0, n);
            chk(35'(n >= DISCHARGE), 35'h1);
            chk(35'(display_on), 35'h0);
            rd(1'b1, 8'h70, 8'h00);
            repeat (3) @(posedge clk_sys);
            reset_n <= 1'b0;
        end
        close_out();
    end
endmodule
